// ==== verilog/hcih_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcih_host
    import hcih_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             rst_pin_n,
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire logic [7:0]       cmd_data,
    output logic                  rsp_valid,
    input  wire logic             rsp_ready,
    output logic [7:0]            rsp_data,
    input  wire hcih_pin_in_type  i2c_in,
    output hcih_pin_out_type      i2c_out
);
    hcih_state_type s_ff;
    hcih_state_type nxt_s;
    logic [7:0]     rpt_mem [0:63];
    logic           buf_we;
    logic [5:0]     buf_wa;
    logic [7:0]     buf_wd;
    logic           push;
    logic [7:0]     push_data;
    logic           pop;
    logic           tick;

    // timer reload for one quarter bit; the timer spends one extra cycle at zero, hence one less
    function automatic logic [9:0] qtr(input logic [7:0] div);
        logic [17:0] p;
        p = (18'(div) + 18'h2) * Q_RATIO;
        return p[Q_SHIFT+9:Q_SHIFT] - 10'h1;
    endfunction : qtr

    function automatic hcih_state_type core_rst(input hcih_state_type cur);
        hcih_state_type r;
        r        = '0;
        r.st     = S_RECV;
        r.div    = DIV_RST;
        r.rs1    = cur.rs1;
        r.rs2    = cur.rs2;
        r.fcnt   = cur.fcnt;
        r.prst   = cur.prst;
        return r;
    endfunction : core_rst

    assign cmd_ready       = (s_ff.st == S_RECV) && !s_ff.prst;
    assign rsp_valid       = (s_ff.cnt != 2'h0);
    assign rsp_data        = s_ff.rp ? s_ff.q1 : s_ff.q0;
    assign pop             = rsp_valid && rsp_ready;
    assign tick            = (s_ff.tmr == 10'h0);
    assign i2c_out.scl_out = 1'b0;
    assign i2c_out.sda_out = 1'b0;
    assign i2c_out.scl_oe  = s_ff.scl_oe;
    assign i2c_out.sda_oe  = s_ff.sda_oe;

    always_comb begin
        nxt_s     = s_ff;
        buf_we    = 1'b0;
        buf_wa    = s_ff.idx;
        buf_wd    = cmd_data;
        push      = 1'b0;
        push_data = rpt_mem[s_ff.idx];
        // reset pin filter: assert only after a low lasting the full filter time
        nxt_s.rs1 = rst_pin_n;
        nxt_s.rs2 = s_ff.rs1;
        if (s_ff.rs2) begin
            nxt_s.fcnt = 8'h0;
            nxt_s.prst = 1'b0;
        end else if (s_ff.fcnt == FILT_CYC - 8'h1) begin
            nxt_s.prst = 1'b1;
        end else begin
            nxt_s.fcnt = s_ff.fcnt + 8'h1;
        end
        if (!tick) begin
            nxt_s.tmr = s_ff.tmr - 10'h1;
        end
        case (s_ff.st)
            S_RECV: begin
                if (cmd_valid) begin
                    buf_we    = 1'b1;
                    nxt_s.idx = s_ff.idx + 6'h1;
                    if (s_ff.idx == RPT_LAST) begin
                        nxt_s.st = S_DECODE;
                    end
                end
            end
            S_DECODE: begin
                nxt_s.code   = rpt_mem[IDX_CODE];
                nxt_s.status = RS_OK;
                nxt_s.idx    = 6'h0;
                nxt_s.st     = S_RESP;
                nxt_s.tmr    = qtr(s_ff.div);
                nxt_s.ph     = 2'h0;
                if (rpt_mem[IDX_CODE] == CMD_STATUS) begin
                    if (rpt_mem[IDX_SPEED] == SUB_SPEED) begin
                        nxt_s.div = rpt_mem[IDX_DIV];
                        nxt_s.tmr = qtr(rpt_mem[IDX_DIV]);
                    end
                    if (rpt_mem[IDX_CANCEL] == SUB_CANCEL && s_ff.cont) begin
                        nxt_s.status = RS_CANCEL;
                        nxt_s.cont   = 1'b0;
                        nxt_s.st     = S_STOP;
                    end
                end else if (rpt_mem[IDX_CODE] == CMD_WRITE || rpt_mem[IDX_CODE] == CMD_READ) begin
                    if (s_ff.cont) begin
                        if ((rpt_mem[IDX_CODE] == CMD_READ) != s_ff.rw) begin
                            nxt_s.status = RS_BADCMD;
                        end else begin
                            nxt_s.idx  = DATA_OFS;
                            nxt_s.sh   = rpt_mem[DATA_OFS];
                            nxt_s.bitn = 4'h0;
                            nxt_s.st   = S_BIT;
                        end
                    end else if ({rpt_mem[IDX_LEN_HI], rpt_mem[IDX_LEN_LO]} == 16'h0) begin
                        nxt_s.status = RS_BADLEN;
                    end else begin
                        nxt_s.len  = {rpt_mem[IDX_LEN_HI], rpt_mem[IDX_LEN_LO]};
                        nxt_s.addr = rpt_mem[IDX_ADDR][6:0];
                        nxt_s.rw   = (rpt_mem[IDX_CODE] == CMD_READ);
                        nxt_s.idx  = DATA_OFS;
                        nxt_s.st   = S_START;
                    end
                end else begin
                    nxt_s.status = RS_BADCMD;
                end
            end
            S_START: begin
                if (tick) begin
                    nxt_s.tmr = qtr(s_ff.div);
                    case (s_ff.ph)
                        2'h0: begin
                            nxt_s.scl_oe = 1'b0;
                            nxt_s.sda_oe = 1'b0;
                            if (i2c_in.scl) begin
                                nxt_s.ph = 2'h1;
                            end
                        end
                        2'h1: begin
                            nxt_s.sda_oe = 1'b1;
                            nxt_s.ph     = 2'h2;
                        end
                        default: begin
                            nxt_s.scl_oe = 1'b1;
                            nxt_s.sh     = {s_ff.addr, s_ff.rw};
                            nxt_s.isaddr = 1'b1;
                            nxt_s.bitn   = 4'h0;
                            nxt_s.ph     = 2'h0;
                            nxt_s.st     = S_BIT;
                        end
                    endcase
                end
            end
            S_BIT: begin
                if (tick) begin
                    nxt_s.tmr = qtr(s_ff.div);
                    case (s_ff.ph)
                        2'h0: begin
                            if (s_ff.bitn == ACK_BIT) begin
                                nxt_s.sda_oe = s_ff.rw && !s_ff.isaddr && (s_ff.len != 16'h1);
                            end else begin
                                nxt_s.sda_oe = (!s_ff.rw || s_ff.isaddr) && !s_ff.sh[7];
                            end
                            nxt_s.ph = 2'h1;
                        end
                        2'h1: begin
                            nxt_s.scl_oe = 1'b0;
                            nxt_s.ph     = 2'h2;
                        end
                        2'h2: begin
                            // client may hold the clock low; poll every cycle until it is seen high
                            if (!i2c_in.scl) begin
                                nxt_s.tmr = 10'h0;
                            end else begin
                                if (s_ff.bitn == ACK_BIT) begin
                                    nxt_s.ack = i2c_in.sda;
                                end else begin
                                    nxt_s.sh = {s_ff.sh[6:0], i2c_in.sda};
                                end
                                nxt_s.ph = 2'h3;
                            end
                        end
                        default: begin
                            nxt_s.scl_oe = 1'b1;
                            nxt_s.ph     = 2'h0;
                            if (s_ff.bitn == ACK_BIT) begin
                                nxt_s.st = S_NEXT;
                            end else begin
                                nxt_s.bitn = s_ff.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            S_NEXT: begin
                nxt_s.bitn = 4'h0;
                nxt_s.st   = S_BIT;
                if (s_ff.isaddr) begin
                    nxt_s.isaddr = 1'b0;
                    nxt_s.sh     = rpt_mem[s_ff.idx];
                    if (s_ff.ack) begin
                        nxt_s.status = RS_NACK;
                        nxt_s.st     = S_STOP;
                    end
                end else if (!s_ff.rw && s_ff.ack) begin
                    nxt_s.status = RS_NACK;
                    nxt_s.st     = S_STOP;
                end else begin
                    if (s_ff.rw) begin
                        buf_we = 1'b1;
                        buf_wd = s_ff.sh;
                    end
                    nxt_s.len = s_ff.len - 16'h1;
                    nxt_s.idx = s_ff.idx + 6'h1;
                    nxt_s.sh  = rpt_mem[s_ff.idx + 6'h1];
                    if (s_ff.len == 16'h1) begin
                        nxt_s.st = S_STOP;
                    end else if (s_ff.idx == RPT_LAST) begin
                        nxt_s.cont = 1'b1;
                        nxt_s.idx  = 6'h0;
                        nxt_s.st   = S_RESP;
                    end
                end
            end
            S_STOP: begin
                if (tick) begin
                    nxt_s.tmr = qtr(s_ff.div);
                    case (s_ff.ph)
                        2'h0: begin
                            nxt_s.scl_oe = 1'b1;
                            nxt_s.sda_oe = 1'b1;
                            nxt_s.ph     = 2'h1;
                        end
                        2'h1: begin
                            nxt_s.scl_oe = 1'b0;
                            if (!s_ff.scl_oe && i2c_in.scl) begin
                                nxt_s.ph = 2'h2;
                            end
                        end
                        default: begin
                            nxt_s.sda_oe = 1'b0;
                            nxt_s.cont   = 1'b0;
                            nxt_s.idx    = 6'h0;
                            nxt_s.ph     = 2'h0;
                            nxt_s.st     = S_RESP;
                        end
                    endcase
                end
            end
            S_RESP: begin
                case (s_ff.idx)
                    IDX_CODE:   push_data = s_ff.code;
                    IDX_STAT:   push_data = s_ff.status;
                    6'h02:      push_data = s_ff.len[7:0];
                    6'h03:      push_data = s_ff.len[15:8];
                    default:    push_data = rpt_mem[s_ff.idx];
                endcase
                if (s_ff.cnt != 2'h2) begin
                    push      = 1'b1;
                    nxt_s.idx = s_ff.idx + 6'h1;
                    if (s_ff.idx == RPT_LAST) begin
                        nxt_s.st = S_RECV;
                    end
                end
            end
            default: nxt_s.st = S_RECV;
        endcase
        // two-entry response buffer
        if (push) begin
            if (s_ff.wp) begin
                nxt_s.q1 = push_data;
            end else begin
                nxt_s.q0 = push_data;
            end
            nxt_s.wp = !s_ff.wp;
        end
        if (pop) begin
            nxt_s.rp = !s_ff.rp;
        end
        nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
        if (s_ff.prst) begin
            nxt_s  = core_rst(nxt_s);
            buf_we = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_ff      <= core_rst('0);
            s_ff.rs1  <= 1'b1;
            s_ff.rs2  <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    always_ff @(posedge clk) begin
        if (buf_we) begin
            rpt_mem[buf_wa] <= buf_wd;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_cancel_req;
        !s_ff.prst && s_ff.st == S_DECODE && s_ff.cont && rpt_mem[IDX_CODE] == CMD_STATUS
            && rpt_mem[IDX_CANCEL] == SUB_CANCEL;
    endsequence
    sequence seq_released;
        s_ff.st == S_STOP ##[1:1000] (s_ff.st == S_RESP && !s_ff.sda_oe && !s_ff.scl_oe);
    endsequence

    a_cancel_frees: assert property (seq_cancel_req |=> seq_released)
        else $error("cancel did not release the bus");
    a_speed_load: assert property (!s_ff.prst && s_ff.st == S_DECODE && rpt_mem[IDX_CODE] == CMD_STATUS
        && rpt_mem[IDX_SPEED] == SUB_SPEED |=> s_ff.div == $past(rpt_mem[IDX_DIV]))
        else $error("divider not loaded");
    a_resp_code: assert property (push && s_ff.st == S_RESP && s_ff.idx == IDX_CODE |-> push_data == rpt_mem[IDX_CODE])
        else $error("response byte 0 is not the command code");
    a_report_len: assert property (!s_ff.prst && push && s_ff.idx == RPT_LAST |=> s_ff.st == S_RECV && s_ff.idx == 6'h0)
        else $error("response report not 64 bytes");
    a_stretch_wait: assert property (!s_ff.prst && s_ff.st == S_BIT && s_ff.ph == 2'h2 && !i2c_in.scl
        |=> s_ff.ph == 2'h2 || s_ff.prst)
        else $error("engine ran on while clock held low");
    a_idle_released: assert property (s_ff.st == S_RECV && !s_ff.cont |-> !s_ff.scl_oe && !s_ff.sda_oe)
        else $error("bus driven while idle");
    a_len_count: assert property (!s_ff.prst && s_ff.st == S_NEXT && !s_ff.isaddr && !s_ff.ack
        |=> s_ff.len == $past(s_ff.len) - 16'h1 || s_ff.prst)
        else $error("length not counted down");
    a_glitch_reject: assert property ($rose(s_ff.prst) |-> $past(!s_ff.rs2) && $past(s_ff.fcnt) == FILT_CYC - 8'h1)
        else $error("reset taken from a short pulse");
    a_reset_hold: assert property (s_ff.prst && !s_ff.rs2 |=> s_ff.prst && s_ff.st == S_RECV && !cmd_ready)
        else $error("reset released while pin low");
endmodule : hcih_host
`default_nettype wire

// ==== verilog/hcih_pkg.sv ====
`default_nettype none
package hcih_pkg;
    localparam int          CLK_MHZ    = 125;
    localparam int          BASE_MHZ   = 12;
    localparam logic [17:0] Q_RATIO    = 18'((32 * CLK_MHZ + BASE_MHZ - 1) / BASE_MHZ);
    localparam int          Q_SHIFT    = 7;
    localparam int          FILT_NS    = 1000;
    localparam logic [7:0]  FILT_CYC   = 8'((FILT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [5:0]  RPT_LAST   = 6'h3f;
    localparam logic [5:0]  DATA_OFS   = 6'h04;
    localparam logic [5:0]  IDX_CODE   = 6'h00;
    localparam logic [5:0]  IDX_STAT   = 6'h01;
    localparam logic [5:0]  IDX_LEN_LO = 6'h01;
    localparam logic [5:0]  IDX_LEN_HI = 6'h02;
    localparam logic [5:0]  IDX_ADDR   = 6'h03;
    localparam logic [5:0]  IDX_CANCEL = 6'h02;
    localparam logic [5:0]  IDX_SPEED  = 6'h03;
    localparam logic [5:0]  IDX_DIV    = 6'h04;
    localparam logic [7:0]  CMD_STATUS = 8'h10;
    localparam logic [7:0]  CMD_WRITE  = 8'h90;
    localparam logic [7:0]  CMD_READ   = 8'h91;
    localparam logic [7:0]  SUB_CANCEL = 8'h10;
    localparam logic [7:0]  SUB_SPEED  = 8'h20;
    localparam logic [7:0]  DIV_RST    = 8'h76;
    localparam logic [7:0]  RS_OK      = 8'h00;
    localparam logic [7:0]  RS_NACK    = 8'h01;
    localparam logic [7:0]  RS_CANCEL  = 8'h02;
    localparam logic [7:0]  RS_BADLEN  = 8'h03;
    localparam logic [7:0]  RS_BADCMD  = 8'h04;
    localparam logic [3:0]  ACK_BIT    = 4'h8;

    typedef enum logic [2:0] {
        S_RECV   = 3'b000,
        S_DECODE = 3'b001,
        S_START  = 3'b010,
        S_BIT    = 3'b011,
        S_NEXT   = 3'b100,
        S_STOP   = 3'b101,
        S_RESP   = 3'b110
    } hcih_st_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } hcih_pin_in_type;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } hcih_pin_out_type;

    typedef struct packed {
        logic        rs1;
        logic        rs2;
        logic [7:0]  fcnt;
        logic        prst;
        hcih_st_type st;
        logic [1:0]  ph;
        logic [9:0]  tmr;
        logic [7:0]  div;
        logic [5:0]  idx;
        logic [15:0] len;
        logic [6:0]  addr;
        logic        rw;
        logic        cont;
        logic        isaddr;
        logic        ack;
        logic [7:0]  sh;
        logic [3:0]  bitn;
        logic [7:0]  code;
        logic [7:0]  status;
        logic        scl_oe;
        logic        sda_oe;
        logic [7:0]  q0;
        logic [7:0]  q1;
        logic        wp;
        logic        rp;
        logic [1:0]  cnt;
    } hcih_state_type;
endpackage : hcih_pkg
`default_nettype wire

// ==== sim/hcih_client.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcih_client #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] stretch,
    output logic            scl_oe,
    output logic            sda_oe
);
    logic [7:0] log_q [64];
    logic [7:0] abyte, sh, rdat;
    logic       sp, dp, act, adr, rd;
    int         bitc, n, hold;

    initial begin
        {scl_oe, sda_oe, act, adr, rd} = 5'h0;
        {sp, dp} = 2'b11;
    end

    always @(posedge clk) begin
        if (hold != 0) begin
            hold--;
            if (hold == 0) scl_oe <= 1'b0;
        end
        if (sp && scl && dp && !sda) begin
            act = 1'b1;
            adr = 1'b1;
            bitc = -1;
            n = 0;
        end else if (sp && scl && !dp && sda) begin
            act = 1'b0;
            sda_oe <= 1'b0;
        end else if (act && !sp && scl) begin
            if (bitc < 8) sh = {sh[6:0], sda};
            else if (rd && !adr && sda) act = 1'b0;
        end else if (act && sp && !scl) begin
            // hold the clock low to slow the host down
            if (stretch != 8'h00) begin
                hold = int'(stretch);
                scl_oe <= 1'b1;
            end
            if (bitc == 8) adr = 1'b0;
            bitc = (bitc == 8) ? 0 : bitc + 1;
            if (bitc == 8) begin
                if (adr) begin
                    abyte = sh;
                    rd = sh[0];
                    act = (sh[7:1] == ADDR);
                    rdat = 8'hc3;
                end else if (rd) rdat = rdat + 8'h11;
                else begin
                    log_q[n] = sh;
                    n++;
                end
            end
            if (!act) sda_oe <= 1'b0;
            else if (bitc == 8) sda_oe <= !rd || adr;
            else sda_oe <= rd && !adr && !rdat[7 - bitc];
        end
        sp <= scl;
        dp <= sda;
    end
endmodule : hcih_client
`default_nettype wire

// ==== sim/hcih_host_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcih_host_tb
    import hcih_pkg::*;
;
    localparam int         LIMIT    = 100000;
    localparam int         RATE_KHZ = 3000;
    localparam logic [7:0] DIV_SET  = 8'(BASE_MHZ * 1000 / RATE_KHZ - 2);
    localparam int         Q        = ((int'(DIV_SET) + 2) * int'(Q_RATIO)) >>> Q_SHIFT;

    logic             clk, sys_rst, rst_pin_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic [7:0]       cmd_data, rsp_data, stretch;
    logic             cl_scl_oe, cl_sda_oe, scl_q;
    hcih_pin_in_type  pin_i;
    hcih_pin_out_type pin_o;
    logic [7:0]       cmd [64];
    logic [7:0]       rsp [64];
    int               miscompares, checks, cyc, t_fall, per_min;

    assign pin_i.scl = !(pin_o.scl_oe || cl_scl_oe);
    assign pin_i.sda = !(pin_o.sda_oe || cl_sda_oe);

    hcih_host i_hcih_host (.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .i2c_in(pin_i), .i2c_out(pin_o));
    hcih_client i_hcih_client (.clk(clk), .scl(pin_i.scl), .sda(pin_i.sda), .stretch(stretch),
        .scl_oe(cl_scl_oe), .sda_oe(cl_sda_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // shortest clock period on the wire, and the run limit
    always @(posedge clk) begin
        cyc++;
        scl_q <= pin_i.scl;
        if (scl_q && !pin_i.scl) begin
            if (cyc - t_fall < per_min) per_min = cyc - t_fall;
            t_fall = cyc;
        end
        if (cyc == LIMIT) begin
            miscompares++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic fill(input logic [7:0] code, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        for (int k = 0; k < 64; k++) cmd[k] = 8'(k * 7 + 1);
        cmd[0] = code;
        cmd[1] = b1;
        cmd[2] = b2;
        cmd[3] = b3;
    endtask : fill

    task automatic xfer(input int stall);
        int w;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_data = cmd[i];
            w = 0;
            while (cmd_ready !== 1'b1 && w < LIMIT) begin
                @(negedge clk);
                w++;
            end
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        w = 0;
        for (int i = 0; i < 64 && w < LIMIT; w++) begin
            if (rsp_valid === 1'b1 && (stall == 0 || w % stall == 0)) begin
                rsp[i] = rsp_data;
                i++;
                rsp_ready = 1'b1;
            end else rsp_ready = 1'b0;
            @(negedge clk);
        end
        rsp_ready = 1'b0;
        check({7'h0, rsp_valid}, 8'h00, "report length");
    endtask : xfer

    task automatic t_speed();
        fill(CMD_STATUS, 8'h00, 8'h00, 8'h21);
        cmd[4] = 8'h00;
        xfer(0);
        check(rsp[1], RS_OK, "status without speed");
        check(i_hcih_host.s_ff.div, DIV_RST, "divider kept");
        fill(CMD_STATUS, 8'h00, 8'h00, SUB_SPEED);
        cmd[4] = DIV_SET;
        xfer(0);
        check(rsp[0], CMD_STATUS, "status code echo");
        check(rsp[1], RS_OK, "status with speed");
        $display("test speed done");
    endtask : t_speed

    task automatic t_write();
        stretch = 8'h3c;
        per_min = LIMIT;
        fill(CMD_WRITE, 8'h03, 8'h00, 8'h2a);
        xfer(3);
        stretch = 8'd0;
        check(rsp[0], CMD_WRITE, "write code echo");
        check(rsp[1], RS_OK, "write status");
        check(i_hcih_client.abyte, 8'h54, "address byte");
        for (int k = 0; k < 3; k++) check(i_hcih_client.log_q[k], cmd[4 + k], "write data");
        check(8'(per_min >= 60), 8'h01, "stretched bit period");
        $display("test write done");
    endtask : t_write

    task automatic t_read();
        per_min = LIMIT;
        fill(CMD_READ, 8'h03, 8'h00, 8'h2a);
        xfer(0);
        check(rsp[0], CMD_READ, "read code echo");
        check(rsp[1], RS_OK, "read status");
        for (int k = 0; k < 3; k++) check(rsp[4 + k], 8'hc3 + 8'(k * 17), "read data");
        check(8'(per_min >= 3 * Q && per_min <= 4 * Q + 4), 8'h01, "bit period");
        $display("test read done");
    endtask : t_read

    task automatic t_nack();
        fill(CMD_WRITE, 8'h01, 8'h00, 8'h15);
        xfer(0);
        check(rsp[1], RS_NACK, "absent client");
        check({6'h0, pin_o.scl_oe, pin_o.sda_oe}, 8'h00, "bus free after nack");
        check({6'h0, pin_o.scl_out, pin_o.sda_out}, 8'h00, "open drain levels");
        fill(CMD_WRITE, 8'h00, 8'h00, 8'h2a);
        xfer(0);
        check(rsp[1], RS_BADLEN, "zero length refused");
        fill(8'h55, 8'h01, 8'h00, 8'h2a);
        xfer(0);
        check(rsp[1], RS_BADCMD, "unknown code");
        check(rsp[0], 8'h55, "unknown code echo");
        $display("test nack done");
    endtask : t_nack

    task automatic t_cancel();
        fill(CMD_WRITE, 8'h3d, 8'h00, 8'h2a);
        xfer(0);
        check(rsp[1], RS_OK, "first part status");
        check(rsp[2], 8'h01, "remaining length");
        check(8'(i_hcih_client.n), 8'h3c, "bytes written");
        check({7'h0, pin_o.scl_oe}, 8'h01, "clock held");
        fill(CMD_READ, 8'h01, 8'h00, 8'h2a);
        xfer(0);
        check(rsp[1], RS_BADCMD, "wrong resume code");
        check({7'h0, pin_o.scl_oe}, 8'h01, "clock still held");
        fill(CMD_STATUS, 8'h00, SUB_CANCEL, 8'h00);
        xfer(0);
        check(rsp[1], RS_CANCEL, "cancel status");
        repeat (4 * Q) @(negedge clk);
        check({6'h0, pin_i.scl, pin_i.sda}, 8'h03, "bus released");
        $display("test cancel done");
    endtask : t_cancel

    task automatic t_rstpin();
        int bad;
        bad = 0;
        @(negedge clk);
        rst_pin_n = 1'b0;
        repeat (100) begin
            @(negedge clk);
            bad += (cmd_ready !== 1'b1);
        end
        rst_pin_n = 1'b1;
        check(8'(bad), 8'h00, "short pulse ignored");
        repeat (10) @(negedge clk);
        rst_pin_n = 1'b0;
        repeat (200) @(negedge clk);
        check({7'h0, cmd_ready}, 8'h00, "held in reset");
        rst_pin_n = 1'b1;
        repeat (10) @(negedge clk);
        check({7'h0, cmd_ready}, 8'h01, "out of reset");
        $display("test reset pin done");
    endtask : t_rstpin

    initial begin
        sys_rst = 1'b1;
        rst_pin_n = 1'b1;
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
        rsp_ready = 1'b0;
        stretch = 8'h00;
        per_min = LIMIT;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_speed();
        t_write();
        t_read();
        t_nack();
        t_cancel();
        t_rstpin();
        print_verdict();
    end
endmodule : hcih_host_tb
`default_nettype wire
